/* core/mcst_params.svh */
// Timing counts, field positions and reset values of the module control and status block
`ifndef MCST_PARAMS_SVH
`define MCST_PARAMS_SVH

// ****************************************
// Clock rate and unit conversion
// ****************************************
`define MCST_CLK_MHZ        25
`define MCST_CLK_KHZ        25000
`define MCST_US2CYC(t)      ((t) * `MCST_CLK_MHZ)
`define MCST_MS2CYC(t)      ((t) * `MCST_CLK_KHZ)
// Pin synchroniser, settle stage and output flop eat into every budget but the reset-pin count, which keeps its full length
`define MCST_LAT            4

// ****************************************
// Documented response times
// ****************************************
`define MCST_T_INIT_MS      2000
`define MCST_T_LP_US        100
`define MCST_T_INT_ON_MS    200
`define MCST_T_INT_OFF_US   500
`define MCST_T_RSTI_US      2
`define MCST_T_SERIAL_MS    2000
`define MCST_T_DATA_MS      2000
`define MCST_T_LOS_MS       100
`define MCST_T_TXF_MS       200
`define MCST_T_FLAG_MS      200
`define MCST_T_MASK_ON_MS   100
`define MCST_T_MASK_OFF_MS  100
`define MCST_T_PDN_ON_MS    100
`define MCST_T_PDN_OFF_MS   300
`define MCST_T_RXSQ_US      80
`define MCST_T_TXSQ_MS      400
`define MCST_T_TXDIS_ON_MS  100
`define MCST_T_TXDIS_OFF_MS 400
`define MCST_T_RXDIS_ON_MS  100
`define MCST_T_RXDIS_OFF_MS 100
`define MCST_T_SQDIS_ON_MS  100
`define MCST_T_SQDIS_OFF_MS 100

// ****************************************
// Cycle counts
// ****************************************
`define MCST_INIT_CYC       (`MCST_MS2CYC(`MCST_T_INIT_MS) - `MCST_LAT)
`define MCST_RSTI_CYC       `MCST_US2CYC(`MCST_T_RSTI_US)
`define MCST_MASK_ON_CYC    (`MCST_MS2CYC(`MCST_T_MASK_ON_MS) - `MCST_LAT)
`define MCST_MASK_OFF_CYC   (`MCST_MS2CYC(`MCST_T_MASK_OFF_MS) - `MCST_LAT)
`define MCST_PDN_ON_CYC     (`MCST_MS2CYC(`MCST_T_PDN_ON_MS) - `MCST_LAT)
`define MCST_PDN_OFF_CYC    (`MCST_MS2CYC(`MCST_T_PDN_OFF_MS) - `MCST_LAT)
`define MCST_RXSQ_CYC       (`MCST_US2CYC(`MCST_T_RXSQ_US) - `MCST_LAT)
`define MCST_TXSQ_CYC       (`MCST_MS2CYC(`MCST_T_TXSQ_MS) - `MCST_LAT)
`define MCST_TXDIS_ON_CYC   (`MCST_MS2CYC(`MCST_T_TXDIS_ON_MS) - `MCST_LAT)
`define MCST_TXDIS_OFF_CYC  (`MCST_MS2CYC(`MCST_T_TXDIS_OFF_MS) - `MCST_LAT)
`define MCST_RXDIS_ON_CYC   (`MCST_MS2CYC(`MCST_T_RXDIS_ON_MS) - `MCST_LAT)
`define MCST_RXDIS_OFF_CYC  (`MCST_MS2CYC(`MCST_T_RXDIS_OFF_MS) - `MCST_LAT)
`define MCST_SQDIS_ON_CYC   (`MCST_MS2CYC(`MCST_T_SQDIS_ON_MS) - `MCST_LAT)
`define MCST_SQDIS_OFF_CYC  (`MCST_MS2CYC(`MCST_T_SQDIS_OFF_MS) - `MCST_LAT)

// ****************************************
// Flag vector layout and reset values
// ****************************************
`define MCST_LANES          4
`define MCST_F_RXLOS        0
`define MCST_F_TXF          4
`define MCST_F_DREADY       8
`define MCST_F_AUX          9
`define MCST_DNR_RST        1'h1
`define MCST_INTERRUPT_OUT_LOW_RST       1'h1
`define MCST_PRS_VAL        1'h0

`endif

/* core/mcst_pkg.sv */
// Types shared by the module control and status block
package mcst_pkg;
    typedef enum logic [1:0] {
        st_reset,
        st_init,
        st_lowpwr,
        st_run
    } mcst_state_t;
endpackage

/* core/mcst_settle.sv */
// Per-bit settle stage: output takes a new input level after a level-dependent count
`timescale 1ns/10ps
module mcst_settle #(
    parameter int unsigned W       = 1,
    parameter int unsigned ON_CYC  = 1,
    parameter int unsigned OFF_CYC = 1
) (
    input  wire logic         clk,       // System clock
    input  wire logic         rst_n,     // Asynchronous reset, active low
    input  wire logic [W-1:0] level_in,  // Requested level
    output logic      [W-1:0] level_out  // Settled level
);
    localparam int unsigned MAXC = (ON_CYC > OFF_CYC) ? ON_CYC : OFF_CYC;
    localparam int unsigned CW   = $clog2(MAXC + 1);

    function automatic logic [CW-1:0] last_of(input int unsigned lim);
        last_of = (lim > 1) ? CW'(lim - 1) : '0;
    endfunction

    for (genvar i = 0; i < W; i++) begin : g_bit
        logic [CW-1:0] cnt;
        logic [CW-1:0] last;

        assign last = level_in[i] ? last_of(ON_CYC) : last_of(OFF_CYC);

        // A level that flips back before the count ends restarts the wait
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                cnt          <= '0;
                level_out[i] <= 1'h0;
            end else if (level_in[i] == level_out[i]) begin
                cnt <= '0;
            end else if (cnt >= last) begin
                cnt          <= '0;
                level_out[i] <= level_in[i];
            end else begin
                cnt <= cnt + CW'(1);
            end
        end

        AST_SETTLE_BOUND: assert property (@(posedge clk) disable iff (!rst_n)
            cnt <= last_of(MAXC))
            else $error("settle counter ran past its limit");
    end
endmodule

/* core/mcst_top.sv */
// Control and status timing of a four-lane pluggable optical module
//
// Contract
// - After power-on, hot plug or reset release, fully functional within 2000 ms.
// - Low-power request brings power level 1 within 100 us.
// - Interrupt output goes low within 200 ms of a triggering condition.
// - Host read clears flags; interrupt output releases within 500 us.
// - Reset pin held low starts internal reset within 2 us.
// - After reset pin rises, fully functional within 2000 ms.
// - Serial bus answers within 2000 ms of power-on.
// - Within 2000 ms of power-on, data-not-ready clears and interrupt asserts.
// - Receive loss of signal sets its bit and interrupt within 100 ms.
// - Transmit fault sets its bit and interrupt within 200 ms.
// - Any other condition sets its flag and interrupt within 200 ms; the code gives transmit input loss (tx_los_in) no flag, only squelch.
// - Setting a mask bit inhibits that flag's interrupt within 100 ms.
// - Clearing a mask bit lets that flag interrupt again within 100 ms.
// - Power-down bit: level 1 within 100 ms, full function 300 ms after clear.
// - Receive squelch on and off within 80 us of signal loss and return.
// - Transmit squelch on and off within 400 ms of signal loss and return.
// - Transmit disable: off within 100 ms, back on within 400 ms.
// - Receive output disable: off within 100 ms, back on within 100 ms.
// - Squelch disable bit turns both squelches off and on within 100 ms.
`timescale 1ns/10ps
`include "mcst_params.svh"
module mcst_top #(
    parameter int unsigned AUX       = 3,
    parameter int unsigned INIT_CYC  = `MCST_INIT_CYC,
    parameter int unsigned MASK_ON   = `MCST_MASK_ON_CYC,
    parameter int unsigned MASK_OFF  = `MCST_MASK_OFF_CYC,
    parameter int unsigned PDN_ON    = `MCST_PDN_ON_CYC,
    parameter int unsigned PDN_OFF   = `MCST_PDN_OFF_CYC,
    parameter int unsigned RXSQ_CYC  = `MCST_RXSQ_CYC,
    parameter int unsigned TXSQ_CYC  = `MCST_TXSQ_CYC,
    parameter int unsigned TXDIS_ON  = `MCST_TXDIS_ON_CYC,
    parameter int unsigned TXDIS_OFF = `MCST_TXDIS_OFF_CYC,
    parameter int unsigned RXDIS_ON  = `MCST_RXDIS_ON_CYC,
    parameter int unsigned RXDIS_OFF = `MCST_RXDIS_OFF_CYC,
    parameter int unsigned SQDIS_ON  = `MCST_SQDIS_ON_CYC,
    parameter int unsigned SQDIS_OFF = `MCST_SQDIS_OFF_CYC,
    parameter int unsigned NF        = `MCST_F_AUX + AUX
) (
    input  wire logic                   clk,                // 25 MHz system clock
    input  wire logic                   rst_n,              // Power-on / hot-plug reset
    input  wire logic                   module_reset_low,   // Reset pin, asynchronous
    input  wire logic                   low_power_request,  // Low-power pin, asynchronous
    input  wire logic [`MCST_LANES-1:0] rx_los_in,          // Receive loss of signal, asynchronous
    input  wire logic [`MCST_LANES-1:0] tx_fault_in,        // Transmit fault, asynchronous
    input  wire logic [`MCST_LANES-1:0] tx_los_in,          // Transmit input lost, asynchronous
    input  wire logic [AUX-1:0]         aux_cond_in,        // Other flag conditions, asynchronous
    input  wire logic [NF-1:0]          flag_mask,          // Interrupt mask per flag
    input  wire logic                   flag_read,          // Host read of the flags, pulse
    input  wire logic [NF-1:0]          flag_read_sel,      // Flags covered by that read
    input  wire logic                   power_down,         // Power-down control bit
    input  wire logic [`MCST_LANES-1:0] tx_disable,         // Transmit disable per lane
    input  wire logic [`MCST_LANES-1:0] rx_disable,         // Receive output disable per lane
    input  wire logic                   squelch_disable,    // Turns off both squelches
    output logic                        interrupt_out_low,  // Interrupt pin, active low
    output logic                        module_present_low, // Presence pin, active low
    output logic                        internal_reset,     // Internal reset in progress
    output logic                        serial_ready,       // Serial bus may be answered
    output logic                        data_not_ready,     // Monitor data not yet valid
    output logic                        fully_functional,   // Module in full operation
    output logic                        power_level1,       // Module held at power level 1
    output logic [NF-1:0]               flag_state,         // Latched flags
    output logic [`MCST_LANES-1:0]      tx_enable,          // Optical transmit on
    output logic [`MCST_LANES-1:0]      rx_out_enable,      // Receive output on
    output logic [`MCST_LANES-1:0]      rx_squelch,         // Receive output squelched
    output logic [`MCST_LANES-1:0]      tx_squelch          // Transmit output squelched
);
    localparam int unsigned L  = `MCST_LANES;
    localparam int unsigned SW = 2 + 3 * L + AUX;
    localparam int RST_LIM     = `MCST_RSTI_CYC;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;

    // Reset pin bit resets to its idle high level, so releasing power-on reset is not seen as a pin reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= {{(SW-1){1'h0}}, 1'h1};
            sync2 <= {{(SW-1){1'h0}}, 1'h1};
        end else begin
            sync1 <= {aux_cond_in, tx_los_in, tx_fault_in, rx_los_in, low_power_request, module_reset_low};
            sync2 <= sync1;
        end
    end

    logic           rst_pin_low;
    logic           lp_s;
    logic [L-1:0]   rx_los_s;
    logic [L-1:0]   tx_fault_s;
    logic [L-1:0]   tx_los_s;
    logic [AUX-1:0] aux_s;

    assign rst_pin_low = ~sync2[0];
    assign lp_s        = sync2[1];
    assign rx_los_s    = sync2[2 +: L];
    assign tx_fault_s  = sync2[2 + L +: L];
    assign tx_los_s    = sync2[2 + 2 * L +: L];
    assign aux_s       = sync2[2 + 3 * L +: AUX];

    // ****************************************
    // Settled control bits
    // ****************************************
    logic [NF-1:0] mask_eff;
    logic          pdn_eff;
    logic [L-1:0]  tx_dis_eff;
    logic [L-1:0]  rx_dis_eff;
    logic          sq_dis_eff;
    logic [L-1:0]  rx_sq_eff;
    logic [L-1:0]  tx_sq_eff;

    mcst_settle #(.W(NF), .ON_CYC(MASK_ON), .OFF_CYC(MASK_OFF)) u_mask (
        .clk       (clk),
        .rst_n     (rst_n),
        .level_in  (flag_mask),
        .level_out (mask_eff)
    );
    mcst_settle #(.W(1), .ON_CYC(PDN_ON), .OFF_CYC(PDN_OFF)) u_pdn (
        .clk       (clk),
        .rst_n     (rst_n),
        .level_in  (power_down),
        .level_out (pdn_eff)
    );
    mcst_settle #(.W(L), .ON_CYC(TXDIS_ON), .OFF_CYC(TXDIS_OFF)) u_txdis (
        .clk       (clk),
        .rst_n     (rst_n),
        .level_in  (tx_disable),
        .level_out (tx_dis_eff)
    );
    mcst_settle #(.W(L), .ON_CYC(RXDIS_ON), .OFF_CYC(RXDIS_OFF)) u_rxdis (
        .clk       (clk),
        .rst_n     (rst_n),
        .level_in  (rx_disable),
        .level_out (rx_dis_eff)
    );
    mcst_settle #(.W(1), .ON_CYC(SQDIS_ON), .OFF_CYC(SQDIS_OFF)) u_sqdis (
        .clk       (clk),
        .rst_n     (rst_n),
        .level_in  (squelch_disable),
        .level_out (sq_dis_eff)
    );
    mcst_settle #(.W(L), .ON_CYC(RXSQ_CYC), .OFF_CYC(RXSQ_CYC)) u_rxsq (
        .clk       (clk),
        .rst_n     (rst_n),
        .level_in  (rx_los_s),
        .level_out (rx_sq_eff)
    );
    mcst_settle #(.W(L), .ON_CYC(TXSQ_CYC), .OFF_CYC(TXSQ_CYC)) u_txsq (
        .clk       (clk),
        .rst_n     (rst_n),
        .level_in  (tx_los_s),
        .level_out (tx_sq_eff)
    );

    // ****************************************
    // Initialisation and power state
    // ****************************************
    mcst_pkg::mcst_state_t state;
    logic [31:0]           init_cnt;
    logic                  init_done;
    logic                  lowpwr_want;

    assign init_done   = (state == mcst_pkg::st_init) && (init_cnt == 32'(INIT_CYC - 1));
    assign lowpwr_want = lp_s | pdn_eff;

    // Power-on starts in init; the reset pin restarts init from scratch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= mcst_pkg::st_init;
        end else if (rst_pin_low) begin
            state <= mcst_pkg::st_reset;
        end else begin
            unique case (state)
                mcst_pkg::st_reset: begin
                    state <= mcst_pkg::st_init;
                end
                mcst_pkg::st_init: begin
                    if (init_done) begin
                        state <= lowpwr_want ? mcst_pkg::st_lowpwr : mcst_pkg::st_run;
                    end
                end
                mcst_pkg::st_lowpwr: begin
                    if (!lowpwr_want) begin
                        state <= mcst_pkg::st_run;
                    end
                end
                mcst_pkg::st_run: begin
                    if (lowpwr_want) begin
                        state <= mcst_pkg::st_lowpwr;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            init_cnt <= '0;
        end else if (state == mcst_pkg::st_init && !rst_pin_low && !init_done) begin
            init_cnt <= init_cnt + 32'h1;
        end else begin
            init_cnt <= '0;
        end
    end

    // The serial bus depends on power-on only; a pin reset leaves it answering
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_ready   <= 1'h0;
            data_not_ready <= `MCST_DNR_RST;
        end else begin
            if (init_done) begin
                serial_ready <= 1'h1;
            end
            if (rst_pin_low) begin
                data_not_ready <= `MCST_DNR_RST;
            end else if (init_done) begin
                data_not_ready <= 1'h0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            internal_reset     <= 1'h0;
            fully_functional   <= 1'h0;
            power_level1       <= 1'h1;
            module_present_low <= `MCST_PRS_VAL;
        end else begin
            internal_reset     <= rst_pin_low;
            fully_functional   <= (state == mcst_pkg::st_run) && !rst_pin_low && !lowpwr_want;
            power_level1       <= lowpwr_want || state != mcst_pkg::st_run;
            module_present_low <= `MCST_PRS_VAL;
        end
    end

    // ****************************************
    // Latched flags and interrupt
    // ****************************************
    logic [NF-1:0] cond_s;
    logic [NF-1:0] cond_prev;
    logic [NF-1:0] cond_rise;
    logic [NF-1:0] rd_clr;
    logic [NF-1:0] flag_keep;
    logic          active;

    assign cond_s    = {aux_s, 1'h0, tx_fault_s, rx_los_s};
    assign cond_rise = (cond_s & ~cond_prev) | (NF'(init_done) << `MCST_F_DREADY);
    assign rd_clr    = flag_read ? flag_read_sel : '0;
    assign flag_keep = flag_state & ~rd_clr;
    assign active    = |(flag_state & ~mask_eff);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cond_prev <= '0;
        end else begin
            cond_prev <= cond_s;
        end
    end

    // A new condition in the cycle of the read wins over the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_state <= '0;
        end else if (rst_pin_low) begin
            flag_state <= '0;
        end else begin
            flag_state <= flag_keep | cond_rise;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_out_low <= `MCST_INTERRUPT_OUT_LOW_RST;
        end else begin
            interrupt_out_low <= ~active;
        end
    end

    // ****************************************
    // Lane outputs
    // ****************************************
    logic [L-1:0] next_rx_squelch;
    logic [L-1:0] next_tx_squelch;
    logic         running;

    assign next_rx_squelch = sq_dis_eff ? '0 : rx_sq_eff;
    assign next_tx_squelch = sq_dis_eff ? '0 : tx_sq_eff;
    assign running         = (state == mcst_pkg::st_run) && !rst_pin_low;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_squelch    <= '0;
            tx_squelch    <= '0;
            tx_enable     <= '0;
            rx_out_enable <= '0;
        end else begin
            rx_squelch    <= next_rx_squelch;
            tx_squelch    <= next_tx_squelch;
            tx_enable     <= running ? ~(tx_dis_eff | next_tx_squelch) : '0;
            rx_out_enable <= running ? ~(rx_dis_eff | next_rx_squelch) : '0;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    AST_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n)
        (|cond_rise && !rst_pin_low) |=> ((flag_state & $past(cond_rise)) == $past(cond_rise)))
        else $error("flag not latched after its condition");

    AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        !rst_pin_low |=> ((flag_state & $past(flag_keep)) == $past(flag_keep)))
        else $error("flag dropped without a read");

    AST_READ_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        (flag_read && !rst_pin_low) |=> ((flag_state & $past(rd_clr & ~cond_rise)) == '0))
        else $error("read did not clear the flag");

    AST_INT_ON: assert property (@(posedge clk) disable iff (!rst_n)
        active |=> !interrupt_out_low)
        else $error("interrupt not asserted for an unmasked flag");

    AST_INT_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        (!active && flag_read) |=> interrupt_out_low)
        else $error("interrupt held with no unmasked flag");

    AST_MASKED: assert property (@(posedge clk) disable iff (!rst_n)
        ((flag_state & ~mask_eff) == '0 && $stable(flag_state)) |=> interrupt_out_low)
        else $error("masked flag still drives the interrupt");

    AST_RESET_ENTER: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_pin_low) |-> ##[1:RST_LIM] (internal_reset && state == mcst_pkg::st_reset))
        else $error("internal reset late");

    AST_INIT_DONE: assert property (@(posedge clk) disable iff (!rst_n)
        (init_done && !rst_pin_low) |=> (!data_not_ready && serial_ready && flag_state[`MCST_F_DREADY]))
        else $error("init end did not mark data ready");

    AST_LOWPWR: assert property (@(posedge clk) disable iff (!rst_n)
        lp_s |=> (power_level1 && !fully_functional))
        else $error("low-power request ignored");

    AST_TX_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        (tx_dis_eff != '0) |=> ((tx_enable & $past(tx_dis_eff)) == '0))
        else $error("disabled lane still transmits");

    AST_SQ_DIS: assert property (@(posedge clk) disable iff (!rst_n)
        sq_dis_eff |=> (rx_squelch == '0 && tx_squelch == '0))
        else $error("squelch active while disabled");
endmodule

/* verif/mcst_host.sv */
// Host controller model: drives the reset pin and issues flag reads
`timescale 1ns/10ps
module mcst_host #(
    parameter int unsigned NF = 12
) (
    input  wire logic     clk,              // System clock
    output logic          module_reset_low, // Reset pin to the module
    output logic          flag_read,        // Flag read strobe
    output logic [NF-1:0] flag_read_sel     // Flags covered by the read
);
    initial begin
        module_reset_low = 1'h1;
        flag_read        = 1'h0;
        flag_read_sel    = {NF{1'h0}};
    end
    // One-cycle read; select is inverted outside the strobe so a late sample sees junk
    task automatic read_flags(input logic [NF-1:0] sel);
        @(negedge clk);
        flag_read     = 1'h1;
        flag_read_sel = sel;
        @(negedge clk);
        flag_read     = 1'h0;
        flag_read_sel = ~sel;
    endtask
    // Caller holds the low level well past the minimum pulse width
    task automatic set_reset(input logic lvl);
        @(negedge clk);
        module_reset_low = lvl;
    endtask
endmodule

/* verif/tb.sv */
// Self-checking bench for the module control and status block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
    localparam int unsigned INIT = 20;
    logic        clk, rst_n, low_power_request, power_down, squelch_disable, module_reset_low, flag_read;
    logic [3:0]  rx_los_in, tx_fault_in, tx_los_in, tx_disable, rx_disable;
    logic [2:0]  aux_cond_in;
    logic [11:0] flag_mask, flag_read_sel, flag_state;
    logic        interrupt_out_low, module_present_low, internal_reset, serial_ready;
    logic        data_not_ready, fully_functional, power_level1;
    logic [3:0]  tx_enable, rx_out_enable, rx_squelch, tx_squelch;
    int          n_fail, compares, ncyc;

    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    mcst_host host (.clk(clk), .module_reset_low(module_reset_low), .flag_read(flag_read),
        .flag_read_sel(flag_read_sel));

    // Shortened counts keep the run small; every settle wait below adds the 4-cycle pipeline allowance
    mcst_top #(.INIT_CYC(INIT), .MASK_ON(4), .MASK_OFF(4), .PDN_ON(4), .PDN_OFF(6), .RXSQ_CYC(5),
        .TXSQ_CYC(8), .TXDIS_ON(4), .TXDIS_OFF(8), .RXDIS_ON(4), .RXDIS_OFF(4), .SQDIS_ON(4),
        .SQDIS_OFF(4)) DUT (.clk(clk), .rst_n(rst_n), .module_reset_low(module_reset_low),
        .low_power_request(low_power_request), .rx_los_in(rx_los_in), .tx_fault_in(tx_fault_in),
        .tx_los_in(tx_los_in), .aux_cond_in(aux_cond_in), .flag_mask(flag_mask), .flag_read(flag_read),
        .flag_read_sel(flag_read_sel), .power_down(power_down), .tx_disable(tx_disable),
        .rx_disable(rx_disable), .squelch_disable(squelch_disable), .interrupt_out_low(interrupt_out_low),
        .module_present_low(module_present_low), .internal_reset(internal_reset),
        .serial_ready(serial_ready), .data_not_ready(data_not_ready), .fully_functional(fully_functional),
        .power_level1(power_level1), .flag_state(flag_state), .tx_enable(tx_enable),
        .rx_out_enable(rx_out_enable), .rx_squelch(rx_squelch), .tx_squelch(tx_squelch));

    task automatic cyc(input int unsigned n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wrap_up;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        ncyc++;
        if (ncyc == 1500) begin
            n_fail++;
            wrap_up();
        end
    end

    initial begin
        rst_n = 1'h0; low_power_request = 1'h0; power_down = 1'h0; squelch_disable = 1'h0;
        rx_los_in = 4'h0; tx_fault_in = 4'h0; tx_los_in = 4'h0; tx_disable = 4'h0; rx_disable = 4'h0;
        aux_cond_in = 3'h0; flag_mask = 12'h000;
        cyc(16);
        `CHK("int_rst", 1'h1, interrupt_out_low)
        `CHK("dnr_rst", 1'h1, data_not_ready)
        rst_n = 1'h1;
        cyc(INIT + 4);
        `CHK("ff", 1'h1, fully_functional)
        `CHK("prs", 1'h0, module_present_low)
        `CHK("irst0", 1'h0, internal_reset)
        `CHK("ser", 1'h1, serial_ready)
        `CHK("dnr", 1'h0, data_not_ready)
        `CHK("dready", 12'h100, flag_state)
        `CHK("int", 1'h0, interrupt_out_low)
        host.read_flags(12'h100);
        cyc(2);
        `CHK("int", 1'h1, interrupt_out_low)
        `CHK("flags", 12'h000, flag_state)
        $display("test init done");
        rx_los_in = 4'h1;
        cyc(4);
        `CHK("rxlos", 12'h001, flag_state)
        `CHK("int", 1'h0, interrupt_out_low)
        cyc(5);
        `CHK("rxsq", 4'h1, rx_squelch)
        rx_los_in = 4'h0;
        cyc(9);
        `CHK("rxsq", 4'h0, rx_squelch)
        `CHK("latch", 12'h001, flag_state)
        flag_mask = 12'h001;
        cyc(8);
        `CHK("int", 1'h1, interrupt_out_low)
        flag_mask = 12'h000;
        cyc(8);
        `CHK("int", 1'h0, interrupt_out_low)
        host.read_flags(12'h001);
        cyc(2);
        `CHK("int", 1'h1, interrupt_out_low)
        tx_fault_in = 4'h2;
        aux_cond_in = 3'h1;
        cyc(4);
        `CHK("txf", 1'h1, flag_state[5])
        `CHK("aux", 1'h1, flag_state[9])
        tx_fault_in = 4'h0;
        aux_cond_in = 3'h0;
        host.read_flags(12'h020);
        cyc(2);
        `CHK("int", 1'h0, interrupt_out_low)
        host.read_flags(12'h200);
        cyc(2);
        `CHK("int", 1'h1, interrupt_out_low)
        $display("test flags done");
        tx_disable = 4'hf;
        rx_disable = 4'hf;
        power_down = 1'h1;
        cyc(8);
        `CHK("txen", 4'h0, tx_enable)
        `CHK("rxen", 4'h0, rx_out_enable)
        `CHK("pl1", 1'h1, power_level1)
        tx_disable = 4'h0;
        rx_disable = 4'h0;
        power_down = 1'h0;
        cyc(8);
        `CHK("rxen", 4'hf, rx_out_enable)
        cyc(4);
        `CHK("txen", 4'hf, tx_enable)
        `CHK("pl1", 1'h0, power_level1)
        `CHK("ff", 1'h1, fully_functional)
        low_power_request = 1'h1;
        cyc(4);
        `CHK("pl1", 1'h1, power_level1)
        `CHK("ff", 1'h0, fully_functional)
        low_power_request = 1'h0;
        tx_los_in = 4'h4;
        cyc(12);
        `CHK("txsq", 4'h4, tx_squelch)
        squelch_disable = 1'h1;
        cyc(8);
        `CHK("txsq", 4'h0, tx_squelch)
        squelch_disable = 1'h0;
        cyc(8);
        `CHK("txsq", 4'h4, tx_squelch)
        tx_los_in = 4'h0;
        cyc(12);
        `CHK("txsq", 4'h0, tx_squelch)
        $display("test controls done");
        host.set_reset(1'h0);
        cyc(4);
        `CHK("irst", 1'h1, internal_reset)
        `CHK("dnr", 1'h1, data_not_ready)
        cyc(250);
        host.set_reset(1'h1);
        cyc(INIT + 4);
        `CHK("ff", 1'h1, fully_functional)
        `CHK("int", 1'h0, interrupt_out_low)
        $display("test pin reset done");
        wrap_up();
    end
endmodule
